// ==== src/tsr_pkg.sv ====
// tsr_pkg: constants for the transmitter status register block
// assumes: included before every tsr_* design file; no clocks or state here
// ----------------------------------------------------------------------------
// package
// ----------------------------------------------------------------------------
package tsr_pkg;

  // bus shape
  localparam int ADDR_W = 9;                          // register address width
  localparam int DATA_W = 8;                          // register data width

  // register offsets
  localparam logic [ADDR_W-1:0] STATUS_OFFSET    = 9'h00e; // transmitter_status, read only
  localparam logic [ADDR_W-1:0] DIAG_CTRL_OFFSET = 9'h01e; // diagnose mode control
  localparam logic [ADDR_W-1:0] ERR_LATCH_OFFSET = 9'h01f; // internal error latch

  // transmitter_status field layout
  localparam int RING_OP_BIT = 7;                     // ring_operational_flag
  localparam int TS_LSB      = 4;                     // transmit_state_code low bit
  localparam int TS_W        = 3;                     // transmit_state_code width
  localparam int TTS_LSB     = 0;                     // transmit_timing_state_code low bit
  localparam int TTS_W       = 4;                     // transmit_timing_state_code width

  // control and latch field positions
  localparam int DIAG_MODE_BIT = 0;                   // diagnose mode enable
  localparam int FSM_ERR_BIT   = 0;                   // transmit_fsm_error_event

  // reset values
  localparam logic [DATA_W-1:0] STATUS_RESET    = 8'h00;
  localparam logic              DIAG_MODE_RESET = 1'b0;
  localparam logic              FSM_ERR_RESET   = 1'b0;

  // transmit_state_code encoding
  localparam logic [TS_W-1:0] TS_IDLE     = 3'h0;
  localparam logic [TS_W-1:0] TS_REPEAT   = 3'h1;
  localparam logic [TS_W-1:0] TS_DATA     = 3'h2;
  localparam logic [TS_W-1:0] TS_TOKEN    = 3'h3;
  localparam logic [TS_W-1:0] TS_CLAIM    = 3'h4;
  localparam logic [TS_W-1:0] TS_BEACON   = 3'h5;
  localparam logic [TS_W-1:0] TS_RESERVED = 3'h6;
  localparam logic [TS_W-1:0] TS_VOID     = 3'h7;

  // transmit_timing_state_code encoding
  localparam logic [TTS_W-1:0] TTS_IDLE     = 4'h0;
  localparam logic [TTS_W-1:0] TTS_PREAMBLE = 4'h1;
  localparam logic [TTS_W-1:0] TTS_WAIT     = 4'h2;
  localparam logic [TTS_W-1:0] TTS_SD_FC    = 4'h3;
  localparam logic [TTS_W-1:0] TTS_DA       = 4'h4;
  localparam logic [TTS_W-1:0] TTS_SA       = 4'h5;
  localparam logic [TTS_W-1:0] TTS_INFO     = 4'h6;
  localparam logic [TTS_W-1:0] TTS_FCS      = 4'h7;
  localparam logic [TTS_W-1:0] TTS_ED_FS    = 4'h8;
  localparam logic [TTS_W-1:0] TTS_LAST     = TTS_ED_FS; // highest legal code

endpackage

// ==== src/tsr_code_check.sv ====
// tsr_code_check: screens raw transmitter state codes against their encodings
// assumes: raw codes come from logic on the same clock; purely combinational
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// code screen
// ----------------------------------------------------------------------------
module tsr_code_check
  import tsr_pkg::*;
(
  input  wire logic [tsr_pkg::TS_W-1:0]  raw_ts,    // live transmit_state_code
  input  wire logic [tsr_pkg::TTS_W-1:0] raw_tts,   // live transmit_timing_state_code
  input  wire logic [tsr_pkg::TS_W-1:0]  held_ts,   // last reported state code
  input  wire logic [tsr_pkg::TTS_W-1:0] held_tts,  // last reported timing code
  output logic      [tsr_pkg::TS_W-1:0]  ok_ts,     // code safe to report
  output logic      [tsr_pkg::TTS_W-1:0] ok_tts,    // code safe to report
  output logic                           code_bad   // a reserved code was seen
);

  import tsr_pkg::*;

  // legal transmit state: every code but the reserved one
  function automatic logic ts_legal(input logic [TS_W-1:0] c);
    return c != TS_RESERVED;
  endfunction

  // legal timing state: idle up to ending delimiter only
  function automatic logic tts_legal(input logic [TTS_W-1:0] c);
    return c <= TTS_LAST;
  endfunction

  // ----------------------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------------------
  // a reserved code keeps the previous legal one, so software never sees it
  always_comb begin
    ok_ts    = ts_legal(raw_ts) ? raw_ts : held_ts;
    ok_tts   = tts_legal(raw_tts) ? raw_tts : held_tts;
    code_bad = !ts_legal(raw_ts) || !tts_legal(raw_tts);
  end

endmodule // tsr_code_check
`default_nettype wire

// ==== src/tsr_status_top.sv ====
// tsr_status_top: transmitter status register with diagnose-mode freeze
// assumes: transmitter inputs are on CORE_CLK; host uses the plain register port
//
// Contract
// - status tracks live state; reads never torn
// - diagnose mode freezes status bits 6-0 until error cleared or diagnose mode left; bit 7 keeps tracking
// - status register sits at address 00Eh
// - bit 7 shows the ring operational flag
// - bits 6-4 transmit state, code 6 never
// - bits 3-0 timing state, codes 9-15 never
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// top module
// ----------------------------------------------------------------------------
module tsr_status_top
  import tsr_pkg::*;
(
  input  wire logic                        CORE_CLK,       // 200 MHz core clock
  input  wire logic                        ARST_N,         // async reset, active low
  // register port
  input  wire logic [tsr_pkg::ADDR_W-1:0]  REG_ADDR,       // register address
  input  wire logic [tsr_pkg::DATA_W-1:0]  REG_WDATA,      // write data
  input  wire logic                        REG_WR,         // write strobe
  input  wire logic                        REG_RD,         // read strobe
  output logic      [tsr_pkg::DATA_W-1:0]  REG_RDATA,      // read data, cycle after strobe
  // live transmitter state
  input  wire logic                        RING_OPERATIONAL_FLAG,     // local ring operational
  input  wire logic [tsr_pkg::TS_W-1:0]    TRANSMIT_STATE_CODE,       // mac transmit state
  input  wire logic [tsr_pkg::TTS_W-1:0]   TRANSMIT_TIMING_STATE_CODE, // timing state
  input  wire logic                        TRANSMIT_FSM_ERROR,        // internal error pulse
  // observation
  output logic                             FROZEN          // status held by diagnose freeze
);

  import tsr_pkg::*;

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic [DATA_W-1:0] status;          // transmitter_status register
  logic [DATA_W-1:0] next_status;     // its next value
  logic              diag_mode;       // diagnose mode enable
  logic              next_diag_mode;
  logic              err_latch;       // transmit_fsm_error_event latch bit
  logic              next_err_latch;
  logic [DATA_W-1:0] rd_data;         // registered read answer
  logic [DATA_W-1:0] next_rd_data;
  logic [TS_W-1:0]   ok_ts;           // screened state code
  logic [TTS_W-1:0]  ok_tts;          // screened timing code
  logic              code_bad;        // reserved code on the inputs
  logic              err_event;       // any internal error this cycle
  logic              freeze;          // hold the state fields
  logic              wr_diag;         // write hits diagnose control
  logic              wr_latch;        // write hits error latch

  // address match, shared by read and write decoding
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------------------
  // code screening
  // ----------------------------------------------------------------------------
  // reserved codes are replaced by the value already held
  tsr_code_check u_code_check (
    .raw_ts   (TRANSMIT_STATE_CODE),
    .raw_tts  (TRANSMIT_TIMING_STATE_CODE),
    .held_ts  (status[TS_LSB +: TS_W]),
    .held_tts (status[TTS_LSB +: TTS_W]),
    .ok_ts    (ok_ts),
    .ok_tts   (ok_tts),
    .code_bad (code_bad)
  );

  // ----------------------------------------------------------------------------
  // error latch and diagnose control
  // ----------------------------------------------------------------------------
  // a reserved code counts as a state machine error, same as the pulse
  always_comb begin
    err_event      = TRANSMIT_FSM_ERROR || code_bad;
    wr_diag        = REG_WR && addr_hit(REG_ADDR, DIAG_CTRL_OFFSET);
    wr_latch       = REG_WR && addr_hit(REG_ADDR, ERR_LATCH_OFFSET);
    next_diag_mode = diag_mode;
    next_err_latch = err_latch;
    // software sets or clears diagnose mode directly
    if (wr_diag) begin
      next_diag_mode = REG_WDATA[DIAG_MODE_BIT];
    end
    // writing zero resets the latch bit; writing one leaves it alone
    if (wr_latch && !REG_WDATA[FSM_ERR_BIT]) begin
      next_err_latch = 1'b0;
    end
    // a new error wins over a clear in the same cycle
    if (err_event) begin
      next_err_latch = 1'b1;
    end
  end

  // freeze only while diagnosing and the error still stands
  always_comb begin
    freeze = diag_mode && err_latch;
  end

  // register the control state
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      diag_mode <= DIAG_MODE_RESET;
      err_latch <= FSM_ERR_RESET;
    end else begin
      diag_mode <= next_diag_mode;
      err_latch <= next_err_latch;
    end
  end

  // ----------------------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------------------
  // resampled every cycle; the erroring cycle itself is still captured, so
  // the frozen value shows the state in which the error arose
  always_comb begin
    next_status = status;
    // ring flag keeps following the wire even during a freeze
    next_status[RING_OP_BIT] = RING_OPERATIONAL_FLAG;
    if (!freeze) begin
      next_status[TS_LSB +: TS_W]   = ok_ts;
      next_status[TTS_LSB +: TTS_W] = ok_tts;
    end
    // host writes never reach this register
  end

  // register the status
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  // one registered snapshot per read, so a read cannot tear across bits
  always_comb begin
    next_rd_data = '0;
    if (REG_RD) begin
      if (addr_hit(REG_ADDR, STATUS_OFFSET)) begin
        next_rd_data = status;
      end else if (addr_hit(REG_ADDR, DIAG_CTRL_OFFSET)) begin
        next_rd_data[DIAG_MODE_BIT] = diag_mode;
      end else if (addr_hit(REG_ADDR, ERR_LATCH_OFFSET)) begin
        next_rd_data[FSM_ERR_BIT] = err_latch;
      end else begin
        next_rd_data = '0;                                         // unmapped reads zero
      end
    end
  end

  // register the answer; it stands one cycle only
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // outputs
  assign REG_RDATA = rd_data;
  assign FROZEN    = freeze;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  // a status read returns the register as it stood at the strobe
  AST_READ_SNAPSHOT: assert property (
    REG_RD && REG_ADDR == STATUS_OFFSET |=> REG_RDATA == $past(status))
    else $error("status read did not return the sampled register");

  // unfrozen fields follow the screened live codes one cycle later
  AST_LIVE_UPDATE: assert property (
    !freeze && !code_bad |=> status[6:0] == {$past(TRANSMIT_STATE_CODE), $past(TRANSMIT_TIMING_STATE_CODE)})
    else $error("status fields did not follow live transmitter state");

  // error in diagnose mode holds the state fields for the next cycles
  AST_FREEZE_HOLD: assert property (
    diag_mode && err_event && !wr_diag ##1 (diag_mode && err_latch)[*3] |-> $stable(status[6:0]))
    else $error("status changed while frozen");

  // an error always leaves the latch set, clear or not
  AST_SET_WINS: assert property (
    err_event |=> err_latch && (!diag_mode || FROZEN))
    else $error("error event lost or freeze missing");

  // address 00e reaches the status register
  AST_STATUS_ADDR: assert property (
    REG_RD && REG_ADDR == 9'h00e |=> REG_RDATA == $past(status))
    else $error("status not mapped at 00e");

  // writes to the status address change neither diagnose mode nor the error latch
  AST_WRITE_IGNORED: assert property (
    REG_WR && REG_ADDR == STATUS_OFFSET && !err_event |=>
      $stable(diag_mode) && $stable(err_latch))
    else $error("write to status disturbed control state");

  // read data stands one cycle only, zero when no read was taken
  AST_RDATA_IDLE: assert property (
    !REG_RD |=> REG_RDATA == '0)
    else $error("read data present without a read strobe");

  // ring flag visible one cycle after it appears
  AST_RING_FLAG: assert property (
    ##1 status[RING_OP_BIT] == $past(RING_OPERATIONAL_FLAG))
    else $error("ring flag bit lags or is wrong");

  // reserved transmit state code never reported
  AST_TS_LEGAL: assert property (
    status[TS_LSB +: TS_W] != TS_RESERVED)
    else $error("reserved transmit state reported");

  // reserved timing codes never reported
  AST_TTS_LEGAL: assert property (
    status[TTS_LSB +: TTS_W] <= TTS_LAST)
    else $error("reserved timing state reported");

  // main scenarios
  COV_FREEZE: cover property (diag_mode && err_event ##1 FROZEN);
  COV_UNFREEZE: cover property (FROZEN ##1 !FROZEN);
  COV_READ_FROZEN: cover property (FROZEN && REG_RD && REG_ADDR == STATUS_OFFSET);
  COV_CLEAR_RACE: cover property (wr_latch && !REG_WDATA[FSM_ERR_BIT] && err_event);

endmodule // tsr_status_top
`default_nettype wire

// ==== tb/mac_transmitter_status_register_test.sv ====
// mac_transmitter_status_register_test: self-checking bench for tsr_status_top
// assumes: tsr_pkg compiled first; the bench drives every port, no partner model
`timescale 1ns/1ps
`default_nettype none
module mac_transmitter_status_register_test;
  import tsr_pkg::*;
  // ----------------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------------
  logic              core_clk;   // 200 MHz
  logic              arst_n;     // async reset, active low
  logic [ADDR_W-1:0] reg_addr;   // register address
  logic [DATA_W-1:0] reg_wdata;  // write data
  logic              reg_wr;     // write strobe
  logic              reg_rd;     // read strobe
  logic [DATA_W-1:0] reg_rdata;  // read data
  logic              ring;       // live ring flag
  logic [TS_W-1:0]   ts;         // live transmit state
  logic [TTS_W-1:0]  tts;        // live timing state
  logic              fsm_err;    // error pulse
  logic              frozen;     // freeze indicator
  logic              rd_seen;    // read data due this cycle
  logic [7:0]        exp_q[$];   // expected read data, oldest first
  logic [7:0]        cur;        // status we expect now
  logic [7:0]        exp_v;      // scratch expectation
  logic [31:0]       seed;       // xorshift state
  int                fails;
  int                comparisons;
  int                i;
  int                j;
  // legal transmit state codes, reserved 6 left out
  logic [TS_W-1:0]   ts_tab[7] = '{TS_IDLE, TS_REPEAT, TS_DATA, TS_TOKEN, TS_CLAIM, TS_BEACON, TS_VOID};

  tsr_status_top dut (
    .CORE_CLK                   (core_clk),
    .ARST_N                     (arst_n),
    .REG_ADDR                   (reg_addr),
    .REG_WDATA                  (reg_wdata),
    .REG_WR                     (reg_wr),
    .REG_RD                     (reg_rd),
    .REG_RDATA                  (reg_rdata),
    .RING_OPERATIONAL_FLAG      (ring),
    .TRANSMIT_STATE_CODE        (ts),
    .TRANSMIT_TIMING_STATE_CODE (tts),
    .TRANSMIT_FSM_ERROR         (fsm_err),
    .FROZEN                     (frozen)
  );

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // case equality so an unknown never matches
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe; expectation queued for the monitor
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask

  // drive live state and let it settle into the register
  task automatic live(input logic r, input logic [TS_W-1:0] s, input logic [TTS_W-1:0] t);
    @(posedge core_clk);
    ring <= r;
    ts   <= s;
    tts  <= t;
    cur  = {r, s, t};
    repeat (2) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------------------
  // monitor: read data stands only in the cycle after the strobe
  // ----------------------------------------------------------------------------
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen) begin
      check(reg_rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx);
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end

  // ----------------------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ring = 1'b0;
    ts = TS_IDLE;
    tts = TTS_IDLE;
    fsm_err = 1'b0;
    rd_seen = 1'b0;
    seed = 32'd17890;
    fails = 0;
    comparisons = 0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    // reset values
    rd(STATUS_OFFSET, STATUS_RESET);
    rd(DIAG_CTRL_OFFSET, 8'h00);
    rd(ERR_LATCH_OFFSET, 8'h00);
    // every legal state and timing pair, random ring flag
    for (i = 0; i < 7; i++) begin
      for (j = 0; j <= 8; j++) begin
        seed = xs(seed);
        live(seed[0], ts_tab[i], 4'(j));
        rd(STATUS_OFFSET, cur);
      end
    end
    // writes to the status register change nothing; unmapped space reads 0
    wr(STATUS_OFFSET, seed[15:8]);
    rd(STATUS_OFFSET, cur);
    wr(9'h0ff, seed[23:16]);
    rd(9'h0ff, 8'h00);
    // reserved timing codes keep the old field
    for (j = 9; j < 16; j++) begin
      seed = xs(seed);
      exp_v = {seed[0], ts_tab[j-9], cur[3:0]};
      live(seed[0], ts_tab[j-9], 4'(j));
      rd(STATUS_OFFSET, exp_v);
      cur = exp_v;
    end
    // reserved state code 6 never shows
    exp_v = {1'b1, cur[6:4], TTS_INFO};
    live(1'b1, TS_RESERVED, TTS_INFO);
    rd(STATUS_OFFSET, exp_v);
    rd(ERR_LATCH_OFFSET, 8'h01);
    live(1'b0, TS_DATA, TTS_SA);
    rd(STATUS_OFFSET, cur);
    wr(ERR_LATCH_OFFSET, 8'h00);
    rd(ERR_LATCH_OFFSET, 8'h00);
    // diagnose freeze: fields hold, ring flag keeps tracking
    wr(DIAG_CTRL_OFFSET, 8'h01);
    rd(DIAG_CTRL_OFFSET, 8'h01);
    live(1'b1, TS_CLAIM, TTS_DA);
    @(posedge core_clk);
    fsm_err <= 1'b1;
    @(posedge core_clk);
    fsm_err <= 1'b0;
    ring    <= 1'b0;
    ts      <= TS_BEACON;
    tts     <= TTS_FCS;
    repeat (2) @(posedge core_clk);
    #1 check({7'h00, frozen}, 8'h01);
    rd(STATUS_OFFSET, {1'b0, TS_CLAIM, TTS_DA});
    // writing one to the latch must not release the freeze
    wr(ERR_LATCH_OFFSET, 8'h01);
    rd(STATUS_OFFSET, {1'b0, TS_CLAIM, TTS_DA});
    wr(ERR_LATCH_OFFSET, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 check({7'h00, frozen}, 8'h00);
    rd(STATUS_OFFSET, {1'b0, TS_BEACON, TTS_FCS});
    // drain outstanding reads, bounded
    for (i = 0; i < 8 && exp_q.size() != 0; i++) begin
      @(posedge core_clk);
    end
    if (exp_q.size() != 0) begin
      fails++;
    end
    close_out();
  end
endmodule // mac_transmitter_status_register_test
`default_nettype wire
